// ### rdm_command_if.sv
/*
  Command, address and data strobe interface of a registered double data
  rate memory module, with its write data FIFO. Assumes the link clock is
  much slower than clk (at least four clk periods per link half cycle) so
  that it can be sampled and its edges found in the clk domain.
*/
`include "rdm_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// Write data FIFO
// ----------------------------------------------------------------------------
module rdm_fifo
  import rdm_pkg::*;
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = `RDM_FIFO_DEPTH
)(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } rdm_fifo_state_type;

  rdm_fifo_state_type r;
  rdm_fifo_state_type next_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (r.count != (AW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer wrap relies on a power of two depth.
  always_comb
  begin
    next_r = r;
    if (push)
    begin
      next_r.mem[r.wr_ptr] = in_data;
      next_r.wr_ptr = r.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_r.rd_ptr = r.rd_ptr + 1'b1;
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule // rdm_fifo

// ----------------------------------------------------------------------------
// Command interface
// ----------------------------------------------------------------------------
module rdm_command_if
  import rdm_pkg::*;
#(
  parameter int READ_LAT = `RDM_READ_LAT,
  parameter int BURST_LEN = `RDM_BURST_LEN,
  parameter int FIFO_DEPTH = `RDM_FIFO_DEPTH,
  parameter int DATA_W = `RDM_DATA_W,
  parameter int CHECK_W = `RDM_CHECK_W
)(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link clock and command pins
  input wire logic link_ck,
  input wire logic sel_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  // Data lines, split into input, output and enable
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [CHECK_W-1:0] check_byte_lines_in,
  output logic [CHECK_W-1:0] check_byte_lines_out,
  output logic check_byte_lines_oe,
  // Data strobe
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe,
  // Decoded commands
  output logic cmd_valid,
  output rdm_cmd_type cmd_code,
  output logic [1:0] cmd_bank,
  output logic [12:0] cmd_row,
  output logic [10:0] cmd_col,
  output logic cmd_auto_precharge,
  output logic cmd_precharge_all,
  output logic [3:0] bank_open,
  output rdm_pwr_type power_state,
  // Read data source
  input wire logic [DATA_W+CHECK_W-1:0] rd_data,
  output logic rd_ready,
  // Write data sink
  output logic [DATA_W+CHECK_W-1:0] wr_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic wr_space
);
  localparam int DW = DATA_W + CHECK_W;

  typedef struct packed {
    logic [2:0] ck_s;
    logic [`RDM_PIN_W-1:0] pin_s1;
    logic [`RDM_PIN_W-1:0] pin_s2;
    logic [`RDM_PIN_W-1:0] pin_reg;
    logic [2:0] dqs_s;
    logic [DW-1:0] dq_s1;
    logic [DW-1:0] dq_s2;
    logic cmd_valid;
    rdm_cmd_type cmd_code;
    logic [1:0] cmd_bank;
    logic [12:0] cmd_row;
    logic [10:0] cmd_col;
    logic cmd_ap;
    logic cmd_all;
    logic [3:0] bank_open;
    rdm_pwr_type pwr;
    logic [`RDM_CNT_W-1:0] rd_lat;
    logic [`RDM_CNT_W-1:0] rd_left;
    logic rd_ap;
    logic [1:0] rd_bank;
    logic [`RDM_CNT_W-1:0] wr_left;
    logic wr_ap;
    logic [1:0] wr_bank;
    logic [DW-1:0] dq_out;
    logic dq_oe;
    logic dqs_out;
  } rdm_if_state_type;

  rdm_if_state_type r;
  rdm_if_state_type next_r;
  logic ck_rise;
  logic ck_fall;
  logic dqs_edge;
  logic rd_start;
  logic rd_beat;
  logic wr_push;
  logic fifo_ready;

  // Maps the three strobe levels to a command.
  function automatic rdm_cmd_type decode_cmd(input logic [2:0] rcw);
    case (rcw)
      `RDM_RCW_MODE: decode_cmd = RDM_CMD_MODE;
      `RDM_RCW_REFRESH: decode_cmd = RDM_CMD_REFRESH;
      `RDM_RCW_PRECHARGE: decode_cmd = RDM_CMD_PRECHARGE;
      `RDM_RCW_ACTIVE: decode_cmd = RDM_CMD_ACTIVE;
      `RDM_RCW_WRITE: decode_cmd = RDM_CMD_WRITE;
      `RDM_RCW_READ: decode_cmd = RDM_CMD_READ;
      `RDM_RCW_STOP: decode_cmd = RDM_CMD_STOP;
      default: decode_cmd = RDM_CMD_NOP;
    endcase
  endfunction

  // Bank number from the bank lines, line 1 being the low bit.
  function automatic logic [1:0] bank_of(input logic [`RDM_PIN_W-1:0] p);
    bank_of = {p[`RDM_BA0_POS], p[`RDM_BA1_POS]}; // [R7]
  endfunction

  // True when this cycle activates the bank; the activate wins over an auto close.
  function automatic logic activates(input rdm_if_state_type n, input logic [1:0] b);
    activates = n.cmd_valid && (n.cmd_code == RDM_CMD_ACTIVE) && (n.cmd_bank == b);
  endfunction

  // Edges of the sampled link clock and strobe; first flops are not looked at.
  assign ck_rise = r.ck_s[1] & ~r.ck_s[2];
  assign ck_fall = ~r.ck_s[1] & r.ck_s[2];
  assign dqs_edge = r.dqs_s[1] ^ r.dqs_s[2]; // [R11]
  assign rd_start = ck_rise && (r.rd_lat == `RDM_CNT_W'(1));
  assign rd_beat = rd_start || ((ck_rise || ck_fall) && (r.rd_left != '0));
  assign wr_push = dqs_edge && (r.wr_left != '0);

  // The whole word goes to the FIFO; masking is not possible here.
  rdm_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(r.dq_s2), // [R15]
    .in_valid(wr_push),
    .in_ready(fifo_ready),
    .out_data(wr_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  // Next state of the interface.
  always_comb
  begin
    next_r = r;
    next_r.ck_s = {r.ck_s[1:0], link_ck};
    next_r.pin_s1 = {cke, sel_n, ras_n, cas_n, we_n, ba[1], ba[0], addr};
    next_r.pin_s2 = r.pin_s1;
    next_r.dqs_s = {r.dqs_s[1:0], dqs_in};
    next_r.dq_s1 = {check_byte_lines_in, dq_in};
    next_r.dq_s2 = r.dq_s1;
    next_r.cmd_valid = 1'b0;
    // The pins are caught only at the link clock rise; this also means a
    // clock enable level held for one full link cycle is always seen.
    if (ck_rise)
    begin
      next_r.pin_reg = r.pin_s2; // [R10] [R9]
      if (r.rd_lat != '0)
      begin
        next_r.rd_lat = r.rd_lat - 1'b1;
      end
      // Clock enable steers the power state before any command.
      if (!r.pin_reg[`RDM_CKE_POS])
      begin
        if (r.pwr == RDM_PWR_ACTIVE)
        begin
          if (!r.pin_reg[`RDM_SEL_POS] &&
              decode_cmd(r.pin_reg[`RDM_WE_POS +: 3]) == RDM_CMD_REFRESH)
          begin
            next_r.pwr = RDM_PWR_SELF_REFRESH; // [R8]
          end
          else
          begin
            next_r.pwr = RDM_PWR_DOWN; // [R8]
          end
        end
      end
      else if (r.pwr != RDM_PWR_ACTIVE)
      begin
        next_r.pwr = RDM_PWR_ACTIVE; // [R8]
      end
      // Commands act only with the module selected and awake.
      else if (!r.pin_reg[`RDM_SEL_POS]) // [R1]
      begin
        next_r.cmd_valid = 1'b1;
        next_r.cmd_code = decode_cmd({r.pin_reg[`RDM_RAS_POS], r.pin_reg[`RDM_CAS_POS],
          r.pin_reg[`RDM_WE_POS]}); // [R2]
        next_r.cmd_bank = bank_of(r.pin_reg);
        next_r.cmd_row = r.pin_reg[`RDM_ADDR_MSB:`RDM_ADDR_LSB]; // [R3]
        next_r.cmd_col = {r.pin_reg[`RDM_COL11_POS], r.pin_reg[9:0]}; // [R4]
        next_r.cmd_ap = r.pin_reg[`RDM_AP_POS]; // [R6]
        next_r.cmd_all = r.pin_reg[`RDM_AP_POS]; // [R5]
        case (next_r.cmd_code)
          RDM_CMD_ACTIVE:
          begin
            next_r.bank_open[bank_of(r.pin_reg)] = 1'b1;
          end
          RDM_CMD_PRECHARGE:
          begin
            if (r.pin_reg[`RDM_AP_POS])
            begin
              next_r.bank_open = '0; // [R5]
            end
            else
            begin
              next_r.bank_open[bank_of(r.pin_reg)] = 1'b0; // [R5]
            end
          end
          RDM_CMD_READ:
          begin
            // Decode already costs one link cycle, the module's register.
            next_r.rd_lat = `RDM_CNT_W'(READ_LAT); // [R14]
            next_r.rd_ap = r.pin_reg[`RDM_AP_POS]; // [R6]
            next_r.rd_bank = bank_of(r.pin_reg);
          end
          RDM_CMD_WRITE:
          begin
            next_r.wr_left = `RDM_CNT_W'(BURST_LEN); // [R11]
            next_r.wr_ap = r.pin_reg[`RDM_AP_POS]; // [R6]
            next_r.wr_bank = bank_of(r.pin_reg);
          end
          RDM_CMD_STOP:
          begin
            next_r.rd_lat = '0;
          end
          default:
          begin
            next_r.cmd_valid = 1'b1;
          end
        endcase
      end
    end
    // Read beats run on both link clock edges, strobe edge aligned; they
    // continue whatever the select line does.
    if (rd_beat)
    begin
      next_r.dq_out = rd_data; // [R16]
      next_r.dq_oe = 1'b1; // [R12]
      next_r.dqs_out = ck_rise; // [R11]
      next_r.rd_left = (rd_start ? `RDM_CNT_W'(BURST_LEN) : r.rd_left) - 1'b1; // [R1]
      if (next_r.rd_left == '0 && r.rd_ap && !activates(next_r, r.rd_bank))
      begin
        next_r.bank_open[r.rd_bank] = 1'b0; // [R6]
      end
    end
    else if ((ck_rise || ck_fall) && r.rd_left == '0)
    begin
      next_r.dq_oe = 1'b0;
      next_r.dqs_out = 1'b0;
    end
    // Write beats are taken on strobe edges; a full FIFO drops the beat.
    if (wr_push)
    begin
      next_r.wr_left = r.wr_left - 1'b1; // [R11]
      if (r.wr_left == `RDM_CNT_W'(1) && r.wr_ap && !activates(next_r, r.wr_bank))
      begin
        next_r.bank_open[r.wr_bank] = 1'b0; // [R6]
      end
    end
  end

  // State register; reset clears every input register and output except wr_space, which the empty FIFO holds high.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0; // [R13]
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs come from the state register, except wr_space, wr_data and wr_valid, which come from the FIFO.
  assign dq_out = r.dq_out[DATA_W-1:0];
  assign check_byte_lines_out = r.dq_out[DW-1:DATA_W];
  assign dq_oe = r.dq_oe; // [R16]
  assign check_byte_lines_oe = r.dq_oe;
  assign dqs_out = r.dqs_out;
  assign dqs_oe = r.dq_oe; // [R12]
  assign cmd_valid = r.cmd_valid;
  assign cmd_code = r.cmd_code;
  assign cmd_bank = r.cmd_bank;
  assign cmd_row = r.cmd_row;
  assign cmd_col = r.cmd_col;
  assign cmd_auto_precharge = r.cmd_ap;
  assign cmd_precharge_all = r.cmd_all;
  assign bank_open = r.bank_open;
  assign power_state = r.pwr;
  assign rd_ready = rd_beat;
  assign wr_space = fifo_ready;
endmodule // rdm_command_if
`default_nettype wire

// ### rdm_defs.svh
/*
  Constants of the registered memory module command interface: pin bundle
  field positions, command line patterns, counter widths and default
  latencies. Assumes it is included by its bare name from each source.
*/
// How it works
// [R1] Module select low accepts commands; high ignores commands but running bursts continue.
// [R2] Each command is decoded from row strobe, column strobe and write enable together.
// [R3] A bank active command captures the row from address lines 0 to 12.
// [R4] Read or write takes the column from lines 0 to 9 plus 11.
// [R5] Precharge closes all banks with line 10 high, else the selected bank.
// [R6] Read or write with line 10 high precharges the bank after the burst.
// [R7] Bank number takes bit 0 from bank line 1, bit 1 from line 0.
// [R8] Clock enable low enters power-down or self-refresh; high again leaves it.
// [R9] The controller holds each clock enable level for at least one link cycle.
// [R10] All inputs except data and strobe are sampled at the link clock rise.
// [R11] Read data follows link clock edges; write data is captured on strobe edges.
// [R12] The strobe is driven by the module on reads, received on writes.
// [R13] Reset low clears every input register and holds register outputs low.
// [R14] Read latency at the pins is the read latency plus one link cycle.
// [R15] Write data is never masked; the mask lines are not used.
// [R16] Data and check byte lines are two-way: write data in, read data out.
`ifndef RDM_DEFS_SVH
`define RDM_DEFS_SVH

// ----------------------------------------------------------------------------
// Pin bundle layout
// ----------------------------------------------------------------------------
`define RDM_PIN_W 20
`define RDM_ADDR_LSB 0
`define RDM_ADDR_MSB 12
`define RDM_BA0_POS 13
`define RDM_BA1_POS 14
`define RDM_WE_POS 15
`define RDM_CAS_POS 16
`define RDM_RAS_POS 17
`define RDM_SEL_POS 18
`define RDM_CKE_POS 19
`define RDM_AP_POS 10
`define RDM_COL11_POS 11

// ----------------------------------------------------------------------------
// Command patterns as {row strobe, column strobe, write enable}, active low
// ----------------------------------------------------------------------------
`define RDM_RCW_MODE 3'h0
`define RDM_RCW_REFRESH 3'h1
`define RDM_RCW_PRECHARGE 3'h2
`define RDM_RCW_ACTIVE 3'h3
`define RDM_RCW_WRITE 3'h4
`define RDM_RCW_READ 3'h5
`define RDM_RCW_STOP 3'h6
`define RDM_RCW_NOP 3'h7

// ----------------------------------------------------------------------------
// Widths and default counts
// ----------------------------------------------------------------------------
`define RDM_CNT_W 4
`define RDM_READ_LAT 3
`define RDM_BURST_LEN 4
`define RDM_FIFO_DEPTH 32
`define RDM_DATA_W 64
`define RDM_CHECK_W 8

`endif

// ### rdm_pkg.sv
/*
  Types shared by the command interface: decoded commands and power states.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package rdm_pkg;

  // Decoded operating commands.
  typedef enum logic [3:0] {RDM_CMD_NOP, RDM_CMD_ACTIVE, RDM_CMD_READ, RDM_CMD_WRITE,
    RDM_CMD_PRECHARGE, RDM_CMD_REFRESH, RDM_CMD_MODE, RDM_CMD_STOP} rdm_cmd_type;

  // Power state held by the clock enable.
  typedef enum logic [1:0] {RDM_PWR_ACTIVE, RDM_PWR_DOWN, RDM_PWR_SELF_REFRESH} rdm_pwr_type;

endpackage
`default_nettype wire

// ### rdm_sva.sv
/*
  Port checker for the registered memory module command interface.
  Assumes it is bound onto rdm_command_if with its default widths.
*/
`timescale 1ns/100ps
`default_nettype none
module rdm_sva
  import rdm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded command outputs
  input wire logic cmd_valid,
  input wire rdm_cmd_type cmd_code,
  input wire logic [1:0] cmd_bank,
  input wire logic cmd_precharge_all,
  input wire logic [3:0] bank_open,
  input wire rdm_pwr_type power_state,
  // Read path
  input wire logic rd_ready,
  input wire logic [71:0] rd_data,
  input wire logic [63:0] dq_out,
  input wire logic [7:0] check_byte_lines_out,
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic check_byte_lines_oe,
  // Write FIFO head
  input wire logic [71:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_ready
);
  // ---------------------------------------------------------------------------
  // Checks on the clk domain
  // ---------------------------------------------------------------------------
  default clocking dclk @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_valid_one_clk: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid lasted more than one clock");
  a_strobe_oe_tie: assert property (dqs_oe == dq_oe && check_byte_lines_oe == dq_oe)
    else $error("strobe or check byte enable differs from data enable");
  // Reset is asynchronous, so this one stays armed while reset is low.
  a_reset_clears: assert property (@(posedge clk) disable iff (1'b0)
    !reset_n |-> !cmd_valid && !dq_oe && bank_open == 4'h0)
    else $error("outputs not cleared in reset");
  a_active_opens: assert property (cmd_valid && cmd_code == RDM_CMD_ACTIVE
    |-> ##[0:2] bank_open[cmd_bank])
    else $error("bank not opened by activate");
  a_close_all: assert property (cmd_valid && cmd_code == RDM_CMD_PRECHARGE
    && cmd_precharge_all |-> ##[0:2] bank_open == 4'h0)
    else $error("banks still open after precharge of all");
  a_read_drives: assert property (rd_ready |=> dq_oe)
    else $error("read beat taken but lines not driven");
  a_read_data: assert property (rd_ready |=>
    {check_byte_lines_out, dq_out} == $past(rd_data))
    else $error("read beat not presented on the data lines");
  a_down_quiet: assert property (power_state == RDM_PWR_DOWN
    && $past(power_state) == RDM_PWR_DOWN |-> !cmd_valid)
    else $error("command accepted in power down");
  a_fifo_holds: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("FIFO head changed without a pop");
endmodule // rdm_sva
`default_nettype wire

// ### rdm_ctrl_model.sv
/*
  Controller model: link clock, command pins, write strobe and write data,
  plus the read beat source. Assumes clk runs at 40 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
module rdm_ctrl_model
(
  // Clock
  input wire logic clk,
  // Link pins
  output logic link_ck,
  output logic sel_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic cke,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic [63:0] dq_in,
  output logic [7:0] check_byte_lines_in,
  output logic dqs_in,
  // Read beat source
  input wire logic rd_ready,
  output logic [71:0] rd_data
);
  logic [2:0] lc = 3'h0;
  logic [7:0] rc = 8'h00;

  // Link clock free runs at clk over eight; each read beat taken moves the source on.
  always @(posedge clk)
  begin
    lc <= lc + 3'h1;
    if (rd_ready === 1'b1)
      rc <= rc + 8'h01;
  end
  assign link_ck = lc[2];
  assign rd_data = {9{rc}};

  // Deselected, clock enabled and idle at time zero.
  initial
  begin
    {sel_n, ras_n, cas_n, we_n, cke, ba, addr} = {5'h1F, 15'h0000};
    {dq_in, check_byte_lines_in, dqs_in} = 73'h0;
  end

  // Pins move at a link fall, giving four clk of setup and hold at the rise.
  task automatic issue(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a,
    input logic s, input logic ce);
    @(negedge link_ck);
    {ras_n, cas_n, we_n} <= rcw;
    {ba, addr, sel_n} <= {b, a, s};
    cke <= ce;
    @(posedge link_ck);
    @(negedge link_ck);
    // Deselected between commands, so idle link cycles are never taken as commands.
    {ras_n, cas_n, we_n, sel_n, addr} <= {3'h7, 1'b1, ~a};
  endtask

  // One beat per link edge after decode; data settles two clk before each edge.
  task automatic write_burst(input logic [7:0] n0);
    @(posedge link_ck);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      {dq_in, check_byte_lines_in} <= {9{n0 + 8'(i)}};
      repeat (2) @(posedge clk);
      dqs_in <= ~dqs_in;
      repeat (2) @(posedge clk);
    end
    {dq_in, check_byte_lines_in} <= ~{9{n0 + 8'h3}};
  endtask
endmodule // rdm_ctrl_model
`default_nettype wire

// ### rdm_tb.sv
/*
  Self-checking bench for the command interface and its write FIFO.
  Assumes the controller model drives every link pin.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
  import rdm_pkg::*;
;
  localparam int RL = 3;
  localparam int BL = 4;
  typedef struct {logic [2:0] rcw; logic [1:0] b; logic [12:0] a; rdm_cmd_type code;} rdm_row_type;
  logic clk = 1'b0;
  logic reset_n;
  logic wr_ready = 1'b0;
  logic link_ck, sel_n, ras_n, cas_n, we_n, cke, dqs_in, dqs_out, dqs_oe, dq_oe;
  logic cmd_valid, cmd_auto_precharge, cmd_precharge_all, rd_ready, wr_valid, wr_space;
  logic check_byte_lines_oe, prev;
  logic [1:0] ba, cmd_bank;
  logic [12:0] addr, cmd_row;
  logic [10:0] cmd_col;
  logic [3:0] bank_open;
  logic [7:0] check_byte_lines_in, check_byte_lines_out;
  logic [63:0] dq_in, dq_out;
  logic [71:0] rd_data, wr_data;
  rdm_cmd_type cmd_code;
  rdm_pwr_type power_state;
  int err_total = 0;
  int check_count = 0;
  int vcount = 0;
  int n;
  rdm_row_type rows [8] = '{'{3'h3, 2'h0, 13'h1555, RDM_CMD_ACTIVE},
    '{3'h3, 2'h1, 13'h0AAA, RDM_CMD_ACTIVE}, '{3'h3, 2'h2, 13'h1FFF, RDM_CMD_ACTIVE},
    '{3'h3, 2'h3, 13'h0001, RDM_CMD_ACTIVE}, '{3'h2, 2'h1, 13'h0000, RDM_CMD_PRECHARGE},
    '{3'h1, 2'h0, 13'h0000, RDM_CMD_REFRESH}, '{3'h0, 2'h0, 13'h0032, RDM_CMD_MODE},
    '{3'h6, 2'h0, 13'h0000, RDM_CMD_STOP}};

  // Clock at 40 MHz; accepted commands are counted so refused ones show up.
  always #12.5 clk = ~clk;
  always @(posedge clk)
    if (cmd_valid === 1'b1)
      vcount++;

  rdm_ctrl_model ctl (.*);
  rdm_command_if #(.READ_LAT(RL), .BURST_LEN(BL)) dut (.*);

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [71:0] exp, input logic [71:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Issue a selected command and wait, bounded, for it to be accepted.
  task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [12:0] a);
    int m;
    m = vcount;
    ctl.issue(rcw, b, a, 1'b0, 1'b1);
    repeat (40)
    begin
      @(posedge clk);
      #1;
      if (vcount != m)
        break;
    end
    chk("accepted", 72'(1), 72'(vcount != m));
    chk("bank", 72'({b[0], b[1]}), 72'(cmd_bank));
  endtask

  task automatic pwr(input logic [2:0] rcw, input logic ce, input rdm_pwr_type exp);
    ctl.issue(rcw, 2'h0, 13'h0000, 1'b0, ce);
    repeat (12) @(posedge clk);
    #1;
    chk("power", 72'(exp), 72'(power_state));
  endtask

  // Reset held for 21 clocks, outputs checked while it is low.
  task automatic rst();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk("reset", 72'h20, 72'({wr_space, wr_valid, dq_oe, cmd_valid, power_state}));
    chk("reset code", 72'(RDM_CMD_NOP), 72'(cmd_code));
    chk("reset banks", 72'h0, 72'(bank_open));
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    reset_n <= 1'b0; // An edge at time zero clears the design before the first clk.
    rst();
    foreach (rows[i])
    begin
      cmd(rows[i].rcw, rows[i].b, rows[i].a);
      chk("code", 72'(rows[i].code), 72'(cmd_code));
      if (rows[i].code == RDM_CMD_ACTIVE)
        chk("row", 72'(rows[i].a), 72'(cmd_row));
    end
    chk("open banks", 72'h0B, 72'(bank_open));
    $display("command table done");
    cmd(3'h5, 2'h0, 13'h0DA5);
    chk("column", 72'h5A5, 72'(cmd_col));
    chk("auto close", 72'h1, 72'(cmd_auto_precharge));
    n = 0;
    prev = link_ck;
    repeat (100)
    begin
      @(posedge clk);
      #1;
      if (rd_ready === 1'b1)
        break;
      if (link_ck && !prev)
        n++;
      prev = link_ck;
    end
    chk("latency", 72'(RL), 72'(n));
    @(posedge clk);
    #1;
    chk("strobe", 72'h7, 72'({dqs_out, dqs_oe, dq_oe}));
    n = 1;
    repeat (8 * BL)
    begin
      @(posedge clk);
      #1;
      if (rd_ready === 1'b1)
        n++;
    end
    chk("beats", 72'(BL), 72'(n));
    chk("lines released", 72'h0, 72'({dq_oe, dqs_oe}));
    chk("closed after", 72'h0, 72'(bank_open[0]));
    cmd(3'h2, 2'h0, 13'h0400);
    chk("all flag", 72'h1, 72'(cmd_precharge_all));
    $display("read and precharge done");
    n = vcount;
    ctl.issue(3'h3, 2'h2, 13'h0000, 1'b1, 1'b1);
    repeat (20) @(posedge clk);
    chk("deselected", 72'(n), 72'(vcount));
    chk("no open", 72'h0, 72'(bank_open));
    pwr(3'h7, 1'b0, RDM_PWR_DOWN);
    n = vcount;
    pwr(3'h3, 1'b0, RDM_PWR_DOWN);
    chk("down ignores", 72'(n), 72'(vcount));
    pwr(3'h7, 1'b1, RDM_PWR_ACTIVE);
    pwr(3'h1, 1'b0, RDM_PWR_SELF_REFRESH);
    pwr(3'h7, 1'b1, RDM_PWR_ACTIVE);
    $display("select and power done");
    cmd(3'h3, 2'h0, 13'h0000);
    for (int k = 0; k < 9; k++)
    begin
      ctl.issue(3'h4, 2'h0, 13'h0000, 1'b0, 1'b1);
      ctl.write_burst(8'(4 * k));
    end
    repeat (4) @(posedge clk);
    chk("full", 72'h0, 72'(wr_space));
    for (int j = 0; j < 32; j++)
    begin
      @(posedge clk);
      #1;
      chk("word", {9{8'(j)}}, wr_data);
      @(posedge clk);
      wr_ready <= 1'b1;
      @(posedge clk);
      wr_ready <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk("drained", 72'h0, 72'(wr_valid));
    $display("write fifo done");
    cmd(3'h3, 2'h3, 13'h0000);
    rst();
    $display("reset done");
    finish_test();
  end

  // Cuts a hang short; the whole run needs well under 10000 clocks.
  initial
  begin
    #250000;
    err_total++;
    finish_test();
  end
endmodule // tb

bind rdm_command_if rdm_sva u_sva (.*);
`default_nettype wire
